/* pkg/tioc_chan_if.sv */
`default_nettype none

// one general register's control and pin traffic
interface tioc_chan_if;
	logic [tioc_pkg::CODE_W-1:0] mode;
	logic                        dis;
	logic [tioc_pkg::GR_W-1:0]   counter;
	logic [tioc_pkg::GR_W-1:0]   gr;
	logic                        pin_in;
	logic                        alt_evt;
	logic                        match_evt;
	logic                        cap;
	logic                        pin_out;
	logic                        pin_oe;

	modport ctl (
		output mode, dis, counter, gr, pin_in, alt_evt,
		input  match_evt, cap, pin_out, pin_oe
	);
	modport unit (
		input  mode, dis, counter, gr, pin_in, alt_evt,
		output match_evt, cap, pin_out, pin_oe
	);
endinterface

`default_nettype wire

/* pkg/tioc_pkg.sv */
// Overview of operation
// - ch3 reg C: bit3 picks compare or capture
// - ch4 reg A bit2: capture on ch3 A event
// - compare, bit2 clear, action set: start low
// - bit2 set starts high; action 00 disables pin
// - action 01 drives pin low on match
// - action 10 drives pin high on match
// - action 11 toggles pin on match
// - capture edge 00 means rising edge only
// - capture edge 01 means falling edge only
// - capture bit1 set means both edges
// - ch3 reg C bit2: capture on ch4 count
// - ch5 reg A ignores bit2, always pin source
// - buffer flag blocks compare and capture on C
`default_nettype none

package tioc_pkg;

	// ---------------------------------------------------------------
	// widths
	// ---------------------------------------------------------------
	localparam int AW     = 8;
	localparam int GR_W   = 16;
	localparam int CODE_W = 4;
	localparam int NCH    = 3;

	// ---------------------------------------------------------------
	// register byte offsets
	// ---------------------------------------------------------------
	localparam logic [AW-1:0] OFS_CODE_3C = 8'h00;
	localparam logic [AW-1:0] OFS_CODE_4A = 8'h04;
	localparam logic [AW-1:0] OFS_CODE_5A = 8'h08;
	localparam logic [AW-1:0] OFS_GR_3C   = 8'h0c;
	localparam logic [AW-1:0] OFS_GR_4A   = 8'h10;
	localparam logic [AW-1:0] OFS_GR_5A   = 8'h14;
	localparam logic [AW-1:0] OFS_STATUS  = 8'h18;
	localparam logic [AW-1:0] OFS_MODE3   = 8'h1c;

	// register indices after decode
	localparam logic [3:0] IDX_CODE  = 4'h0;
	localparam logic [3:0] IDX_GR    = 4'h3;
	localparam logic [3:0] IDX_STAT  = 4'h6;
	localparam logic [3:0] IDX_MODE3 = 4'h7;
	localparam logic [3:0] IDX_NONE  = 4'hf;

	// ---------------------------------------------------------------
	// control code fields and values
	// ---------------------------------------------------------------
	localparam int BIT_MODE  = 3;
	localparam int BIT_LEVEL = 2;
	localparam logic [1:0] ACT_OFF  = 2'h0;
	localparam logic [1:0] ACT_LOW  = 2'h1;
	localparam logic [1:0] ACT_HIGH = 2'h2;
	localparam logic [1:0] ACT_TOG  = 2'h3;
	localparam logic [1:0] EDGE_RISE = 2'h0;
	localparam logic [1:0] EDGE_FALL = 2'h1;

	// status field positions
	localparam int ST_OUT   = 0;
	localparam int ST_OE    = 4;
	localparam int ST_CAP   = 8;
	localparam int ST_MATCH = 12;

	// ---------------------------------------------------------------
	// reset values and channel map
	// ---------------------------------------------------------------
	localparam logic [CODE_W-1:0] CODE_RST = 4'h0;
	localparam logic [GR_W-1:0]   GR_RST   = 16'hffff;
	localparam logic [NCH-1:0]    ALT_SRC_EN = 3'h3;  // 3C and 4A cascade
	localparam int CH_3C = 0;

endpackage

`default_nettype wire

/* rtl/tioc_chan_unit.sv */
`default_nettype none

module tioc_chan_unit #(
	parameter bit ALT_EN = 1'b0
) (
	// clock and reset
	input  wire logic  ref_clk,
	input  wire logic  rst_n,
	// channel traffic
	tioc_chan_if.unit  bus
);

	// ---------------------------------------------------------------
	// decode
	// ---------------------------------------------------------------
	logic                        pin_q;
	logic                        eq_q;
	logic [tioc_pkg::CODE_W-1:0] mode_q;
	logic                        is_cmp;
	logic                        is_cap;
	logic [1:0]                  act;
	logic                        rise;
	logic                        fall;
	logic                        mode_chg;

	// a buffer-register flag silences both uses
	assign is_cmp   = !bus.mode[tioc_pkg::BIT_MODE] && !bus.dis;
	assign is_cap   = bus.mode[tioc_pkg::BIT_MODE] && !bus.dis;
	assign act      = bus.mode[1:0];
	assign rise     = bus.pin_in && !pin_q;
	assign fall     = !bus.pin_in && pin_q;
	assign mode_chg = bus.mode != mode_q;

	// match only on the cycle equality starts, so a stalled counter
	// does not toggle the pin every clock
	assign bus.match_evt = is_cmp && (bus.counter == bus.gr) && !eq_q;

	// capture source and edge select
	always_comb begin
		if (!is_cap)
			bus.cap = 1'b0;
		else if (ALT_EN && bus.mode[tioc_pkg::BIT_LEVEL])
			bus.cap = bus.alt_evt;
		else if (bus.mode[1])
			bus.cap = rise || fall;
		else if (act == tioc_pkg::EDGE_FALL)
			bus.cap = fall;
		else
			bus.cap = rise;
	end

	// ---------------------------------------------------------------
	// history
	// ---------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_q  <= 1'b0;
			eq_q   <= 1'b0;
			mode_q <= tioc_pkg::CODE_RST;
		end else begin
			pin_q  <= bus.pin_in;
			eq_q   <= bus.counter == bus.gr;
			mode_q <= bus.mode;
		end
	end

	// output enable: off in capture mode and for action 00
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			bus.pin_oe <= 1'b0;
		else
			bus.pin_oe <= is_cmp && (act != tioc_pkg::ACT_OFF);
	end

	// pin level: a new code loads the initial level, then matches act
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			bus.pin_out <= 1'b0;
		else if (is_cmp && act != tioc_pkg::ACT_OFF) begin
			if (mode_chg)
				bus.pin_out <= bus.mode[tioc_pkg::BIT_LEVEL];
			else if (bus.match_evt) begin
				case (act)
					tioc_pkg::ACT_LOW:  bus.pin_out <= 1'b0;
					tioc_pkg::ACT_HIGH: bus.pin_out <= 1'b1;
					tioc_pkg::ACT_TOG:  bus.pin_out <= !bus.pin_out;
					default:            bus.pin_out <= bus.pin_out;
				endcase
			end
		end
	end

endmodule // tioc_chan_unit

`default_nettype wire

/* rtl/tioc_top.sv */
// The APB interface to the registers and the placing of the registers were chosen for this implementation.
`default_nettype none

module tioc_top (
	// clock and reset
	input  wire logic                        ref_clk,
	input  wire logic                        rst_n,
	// apb slave
	input  wire logic                        psel,
	input  wire logic                        penable,
	input  wire logic                        pwrite,
	input  wire logic [tioc_pkg::AW-1:0]     paddr,
	input  wire logic [31:0]                 pwdata,
	output logic      [31:0]                 prdata,
	output logic                             pready,
	output logic                             pslverr,
	// counters of the owning channels
	input  wire logic [tioc_pkg::GR_W-1:0]   ch3_counter,
	input  wire logic [tioc_pkg::GR_W-1:0]   ch4_counter,
	input  wire logic [tioc_pkg::GR_W-1:0]   ch5_counter,
	// cascade sources
	input  wire logic                        ch4_count_evt,
	input  wire logic                        ch3_reg_a_evt,
	// timer pins
	input  wire logic                        ch3_pin_c_in,
	output logic                             ch3_pin_c_out,
	output logic                             ch3_pin_c_oe,
	input  wire logic                        ch4_pin_a_in,
	output logic                             ch4_pin_a_out,
	output logic                             ch4_pin_a_oe,
	input  wire logic                        ch5_pin_a_in,
	output logic                             ch5_pin_a_out,
	output logic                             ch5_pin_a_oe
);

	localparam int NCH  = tioc_pkg::NCH;
	localparam int GR_W = tioc_pkg::GR_W;

	// ---------------------------------------------------------------
	// address decode
	// ---------------------------------------------------------------

	// maps a byte address to a register index, IDX_NONE if unmapped
	function automatic logic [3:0] reg_index(input logic [tioc_pkg::AW-1:0] a);
		case (a)
			tioc_pkg::OFS_CODE_3C: reg_index = tioc_pkg::IDX_CODE;
			tioc_pkg::OFS_CODE_4A: reg_index = tioc_pkg::IDX_CODE + 4'h1;
			tioc_pkg::OFS_CODE_5A: reg_index = tioc_pkg::IDX_CODE + 4'h2;
			tioc_pkg::OFS_GR_3C:   reg_index = tioc_pkg::IDX_GR;
			tioc_pkg::OFS_GR_4A:   reg_index = tioc_pkg::IDX_GR + 4'h1;
			tioc_pkg::OFS_GR_5A:   reg_index = tioc_pkg::IDX_GR + 4'h2;
			tioc_pkg::OFS_STATUS:  reg_index = tioc_pkg::IDX_STAT;
			tioc_pkg::OFS_MODE3:   reg_index = tioc_pkg::IDX_MODE3;
			default:               reg_index = tioc_pkg::IDX_NONE;
		endcase
	endfunction

	logic [3:0] idx;
	logic       wr_go;

	assign idx = reg_index(paddr);

	// a write lands only at the completing access edge
	assign wr_go = psel && penable && pready && pwrite
		&& (idx != tioc_pkg::IDX_NONE);

	// ---------------------------------------------------------------
	// register state
	// ---------------------------------------------------------------
	logic [NCH-1:0][tioc_pkg::CODE_W-1:0] code;
	logic [NCH-1:0][GR_W-1:0]             gr;
	logic                                 buffer_mode_a_flag;
	logic [NCH-1:0]                       cap_seen;
	logic [NCH-1:0]                       match_seen;

	// per-channel gathered signals
	logic [NCH-1:0][GR_W-1:0] cnt;
	logic [NCH-1:0]           pin_v;
	logic [NCH-1:0]           alt_v;
	logic [NCH-1:0]           dis_v;
	logic [NCH-1:0]           cap_v;
	logic [NCH-1:0]           match_v;
	logic [NCH-1:0]           out_v;
	logic [NCH-1:0]           oe_v;

	assign cnt   = {ch5_counter, ch4_counter, ch3_counter};
	assign pin_v = {ch5_pin_a_in, ch4_pin_a_in, ch3_pin_c_in};
	// 3C cascades from ch4 counting, 4A from ch3 reg A; 5A has none
	assign alt_v = {1'b0, ch3_reg_a_evt, ch4_count_evt};
	// only reg C of ch3 can be turned into a buffer register
	assign dis_v = {2'b00, buffer_mode_a_flag};

	// control codes, one per covered general register
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			code <= {NCH{tioc_pkg::CODE_RST}};
		end else begin
			for (int i = 0; i < NCH; i++) begin
				if (wr_go && idx == tioc_pkg::IDX_CODE + 4'(i))
					code[i] <= pwdata[tioc_pkg::CODE_W-1:0];
			end
		end
	end

	// buffer-mode flag of channel 3
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			buffer_mode_a_flag <= 1'b0;
		else if (wr_go && idx == tioc_pkg::IDX_MODE3)
			buffer_mode_a_flag <= pwdata[0];
	end

	// general registers: a capture wins over a software write in the
	// same cycle, so a measured edge is never lost
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			gr <= {NCH{tioc_pkg::GR_RST}};
		end else begin
			for (int i = 0; i < NCH; i++) begin
				if (cap_v[i])
					gr[i] <= cnt[i];
				else if (wr_go && idx == tioc_pkg::IDX_GR + 4'(i))
					gr[i] <= pwdata[GR_W-1:0];
			end
		end
	end

	// sticky event flags, write one to clear; a new event beats the clear
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cap_seen   <= '0;
			match_seen <= '0;
		end else if (wr_go && idx == tioc_pkg::IDX_STAT) begin
			cap_seen   <= (cap_seen &
				~pwdata[tioc_pkg::ST_CAP +: NCH]) | cap_v;
			match_seen <= (match_seen &
				~pwdata[tioc_pkg::ST_MATCH +: NCH]) | match_v;
		end else begin
			cap_seen   <= cap_seen | cap_v;
			match_seen <= match_seen | match_v;
		end
	end

	// ---------------------------------------------------------------
	// apb read and answer
	// ---------------------------------------------------------------
	logic [31:0] rd_mux;

	// read value for the addressed register
	always_comb begin
		rd_mux = 32'h0000_0000;
		case (idx)
			4'h0, 4'h1, 4'h2:
				rd_mux[tioc_pkg::CODE_W-1:0] = code[2'(idx)];
			4'h3, 4'h4, 4'h5:
				rd_mux[GR_W-1:0] = gr[2'(idx - tioc_pkg::IDX_GR)];
			tioc_pkg::IDX_STAT: begin
				rd_mux[tioc_pkg::ST_OUT +: NCH]   = out_v;
				rd_mux[tioc_pkg::ST_OE +: NCH]    = oe_v;
				rd_mux[tioc_pkg::ST_CAP +: NCH]   = cap_seen;
				rd_mux[tioc_pkg::ST_MATCH +: NCH] = match_seen;
			end
			tioc_pkg::IDX_MODE3:
				rd_mux[0] = buffer_mode_a_flag;
			default:
				rd_mux = 32'h0000_0000;
		endcase
	end

	// answer in the first access cycle; data is sampled at setup, so a
	// capture in the setup cycle shows on the next read only
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else if (psel && !penable) begin
			pready  <= 1'b1;
			pslverr <= idx == tioc_pkg::IDX_NONE;
			if (!pwrite)
				prdata <= rd_mux;
		end else begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// channel units
	// ---------------------------------------------------------------
	tioc_chan_if ch_if [NCH] ();

	for (genvar g = 0; g < NCH; g++) begin : g_ch
		assign ch_if[g].mode    = code[g];
		assign ch_if[g].dis     = dis_v[g];
		assign ch_if[g].counter = cnt[g];
		assign ch_if[g].gr      = gr[g];
		assign ch_if[g].pin_in  = pin_v[g];
		assign ch_if[g].alt_evt = alt_v[g];
		assign cap_v[g]         = ch_if[g].cap;
		assign match_v[g]       = ch_if[g].match_evt;
		assign out_v[g]         = ch_if[g].pin_out;
		assign oe_v[g]          = ch_if[g].pin_oe;

		// ch5 never takes the cascade path
		tioc_chan_unit #(
			.ALT_EN (tioc_pkg::ALT_SRC_EN[g])
		) u_unit (
			.ref_clk (ref_clk),
			.rst_n   (rst_n),
			.bus     (ch_if[g])
		);
	end

	// pins straight from the unit flops
	assign ch3_pin_c_out = out_v[0];
	assign ch3_pin_c_oe  = oe_v[0];
	assign ch4_pin_a_out = out_v[1];
	assign ch4_pin_a_oe  = oe_v[1];
	assign ch5_pin_a_out = out_v[2];
	assign ch5_pin_a_oe  = oe_v[2];

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	// checks read the register state, not the unit's own nets, so a
	// decode slip inside the unit cannot hide from them
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);

	for (genvar g = 0; g < NCH; g++) begin : g_chk
		logic       cmp_on;
		logic       alt_sel;
		logic [1:0] act;

		assign cmp_on  = !code[g][tioc_pkg::BIT_MODE] && !dis_v[g];
		assign alt_sel = tioc_pkg::ALT_SRC_EN[g]
			&& code[g][tioc_pkg::BIT_LEVEL];
		assign act     = code[g][1:0];

		property p_capture_quiet;
			code[g][tioc_pkg::BIT_MODE] |=> !oe_v[g];
		endproperty
		a_capture_quiet: assert property (p_capture_quiet)
			else $error("pin driven in capture mode");

		property p_compare_no_cap;
			!code[g][tioc_pkg::BIT_MODE] |-> !cap_v[g];
		endproperty
		a_compare_no_cap: assert property (p_compare_no_cap)
			else $error("capture in compare mode");

		property p_init_low;
			($changed(code[g]) && cmp_on && act != tioc_pkg::ACT_OFF
				&& !code[g][tioc_pkg::BIT_LEVEL])
				|=> (!out_v[g] && oe_v[g]);
		endproperty
		a_init_low: assert property (p_init_low)
			else $error("initial level not low");

		property p_init_high;
			($changed(code[g]) && cmp_on && act != tioc_pkg::ACT_OFF
				&& code[g][tioc_pkg::BIT_LEVEL])
				|=> (out_v[g] && oe_v[g]);
		endproperty
		a_init_high: assert property (p_init_high)
			else $error("initial level not high");

		property p_act_off;
			(act == tioc_pkg::ACT_OFF) [*2] |-> !oe_v[g];
		endproperty
		a_act_off: assert property (p_act_off)
			else $error("pin driven with action 00");

		property p_match_low;
			(match_v[g] && act == tioc_pkg::ACT_LOW && $stable(code[g]))
				|=> !out_v[g];
		endproperty
		a_match_low: assert property (p_match_low)
			else $error("match did not drive low");

		property p_match_high;
			(match_v[g] && act == tioc_pkg::ACT_HIGH && $stable(code[g]))
				|=> out_v[g];
		endproperty
		a_match_high: assert property (p_match_high)
			else $error("match did not drive high");

		property p_match_tog;
			(match_v[g] && act == tioc_pkg::ACT_TOG && $stable(code[g]))
				|=> (out_v[g] != $past(out_v[g]));
		endproperty
		a_match_tog: assert property (p_match_tog)
			else $error("match did not toggle");

		property p_cap_rise;
			(cap_v[g] && !alt_sel && act == tioc_pkg::EDGE_RISE)
				|-> $rose(pin_v[g]);
		endproperty
		a_cap_rise: assert property (p_cap_rise)
			else $error("capture without rising edge");

		property p_cap_fall;
			(cap_v[g] && !alt_sel && act == tioc_pkg::EDGE_FALL)
				|-> $fell(pin_v[g]);
		endproperty
		a_cap_fall: assert property (p_cap_fall)
			else $error("capture without falling edge");

		property p_cap_both;
			(code[g][tioc_pkg::BIT_MODE] && !dis_v[g] && !alt_sel
				&& code[g][1] && !$stable(pin_v[g])) |-> cap_v[g];
		endproperty
		a_cap_both: assert property (p_cap_both)
			else $error("edge missed in both-edge mode");

		property p_cap_alt;
			(code[g][tioc_pkg::BIT_MODE] && !dis_v[g] && alt_sel
				&& alt_v[g]) |-> cap_v[g];
		endproperty
		a_cap_alt: assert property (p_cap_alt)
			else $error("cascade event not captured");

		property p_pin_only;
			(!tioc_pkg::ALT_SRC_EN[g] && $stable(pin_v[g])) |-> !cap_v[g];
		endproperty
		a_pin_only: assert property (p_pin_only)
			else $error("capture without pin edge");

		property p_buffer_off;
			dis_v[g] |-> (!cap_v[g] && !match_v[g]) ##1 !oe_v[g];
		endproperty
		a_buffer_off: assert property (p_buffer_off)
			else $error("buffer register still active");

		property p_cap_value;
			cap_v[g] |=> (gr[g] == $past(cnt[g]));
		endproperty
		a_cap_value: assert property (p_cap_value)
			else $error("captured value is not the counter");
	end

endmodule // tioc_top

`default_nettype wire

/* testbench/tb_top.sv */
`default_nettype none

module tb_top;
	timeunit 1ns;
	timeprecision 1ps;

	// ---------------------------------------------------------------
	// signals
	// ---------------------------------------------------------------
	logic             ref_clk, rst_n, psel, penable, pwrite, run, evt_req;
	logic [7:0]       paddr;
	logic [31:0]      pwdata, prdata, rdat, m;
	logic             pready, pslverr, rerr, cnt_evt, reg_a_evt;
	logic [2:0]       ext, pin_in;
	wire logic [2:0]  pout, poe;
	logic [15:0]      cnt, exp_v;
	wire logic [15:0] ctr [3];
	int               errors, total_checks, cycles;

	// distinct counter values per channel catch a swapped counter
	assign ctr[0] = cnt;
	assign ctr[1] = cnt + 16'h0100;
	assign ctr[2] = cnt + 16'h0200;

	tioc_top i_tioc_top (
		.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .ch3_counter(ctr[0]), .ch4_counter(ctr[1]),
		.ch5_counter(ctr[2]), .ch4_count_evt(cnt_evt),
		.ch3_reg_a_evt(reg_a_evt), .ch3_pin_c_in(pin_in[0]),
		.ch3_pin_c_out(pout[0]), .ch3_pin_c_oe(poe[0]),
		.ch4_pin_a_in(pin_in[1]), .ch4_pin_a_out(pout[1]),
		.ch4_pin_a_oe(poe[1]), .ch5_pin_a_in(pin_in[2]),
		.ch5_pin_a_out(pout[2]), .ch5_pin_a_oe(poe[2]));

	tioc_far_model i_tioc_far_model (
		.ref_clk(ref_clk), .rst_n(rst_n), .run(run),
		.evt_req(evt_req), .ext(ext), .out(pout), .oe(poe),
		.cnt(cnt), .cnt_evt(cnt_evt), .reg_a_evt(reg_a_evt),
		.pin(pin_in));

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		total_checks++;
		if (seen !== want) begin
			errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen,
				want);
		end
	endtask

	// one apb transfer; an idle edge follows so requests never collide
	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] d);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		do @(posedge ref_clk); while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge ref_clk);
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
	endtask

	// pin capture expected for an edge code and a transition
	function automatic bit cap_hit(logic [1:0] e, bit rise);
		return e[1] | ((e == 2'h0) ? rise : !rise);
	endfunction

	// pin level after one compare match
	function automatic logic match_lvl(logic [1:0] act, logic cur);
		if (act == 2'h1) return 1'b0;
		if (act == 2'h2) return 1'b1;
		return ~cur;
	endfunction

	task automatic end_of_test;
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// ---------------------------------------------------------------
	// clock and hang guard
	// ---------------------------------------------------------------
	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end

	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 8000) begin
			errors++;
			end_of_test();
		end
	end

	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial begin
		{psel, penable, pwrite, run, evt_req} = 5'h00;
		{paddr, pwdata, ext} = '0;
		rst_n = 1'b0;
		repeat (10) @(posedge ref_clk);
		rst_n <= 1'b1;
		void'($urandom(65));
		@(posedge ref_clk);
		// reset state and an unmapped place
		for (int ch = 0; ch < 3; ch++) begin
			apb(1'b0, 8'(4 * ch), 32'h0);
			check(rdat, 32'h0);
			apb(1'b0, 8'(8'h0c + 4 * ch), 32'h0);
			check(rdat, 32'h0000ffff);
		end
		check(poe, 3'h0);
		apb(1'b0, 8'h40, 32'h0);
		check(rerr, 1'b1);
		// every compare code: initial level, enable, action at match
		for (int ch = 0; ch < 3; ch++)
			for (int c = 0; c < 8; c++) begin
				apb(1'b1, 8'(8'h0c + 4 * ch), {16'h0, ctr[ch] + 16'h0006});
				apb(1'b1, 8'(4 * ch), 32'(c));
				cyc(2);
				check(poe[ch], c[1:0] != 2'h0);
				if (c[1:0] != 2'h0) check(pout[ch], c[2]);
				run <= 1'b1;
				cyc(10);
				run <= 1'b0;
				cyc(2);
				if (c[1:0] != 2'h0)
					check(pout[ch], match_lvl(c[1:0], c[2]));
			end
		// every capture edge code, both transitions, counter running
		for (int ch = 0; ch < 3; ch++)
			for (int c = 0; c < 8; c++) begin
				ext[ch] <= ~c[0];
				apb(1'b1, 8'(4 * ch),
					{28'h0, 1'b1, (ch == 2) ? 1'($urandom) : 1'b0, c[2:1]});
				m = {16'h0, 16'($urandom)};
				apb(1'b1, 8'(8'h0c + 4 * ch), m);
				run <= 1'b1;
				cyc(3);
				ext[ch] <= c[0];
				@(negedge ref_clk) exp_v = ctr[ch];
				cyc(4);
				run <= 1'b0;
				apb(1'b0, 8'(8'h0c + 4 * ch), 32'h0);
				if (cap_hit(c[2:1], c[0]))
					m = {16'h0, exp_v};
				check(rdat, m);
			end
		// cascade sources: pin ignored, neighbour event captures
		for (int ch = 0; ch < 2; ch++) begin
			apb(1'b1, 8'(4 * ch), {28'h0, 2'h3, 2'($urandom)});
			m = {16'h0, 16'($urandom)};
			apb(1'b1, 8'(8'h0c + 4 * ch), m);
			ext[ch] <= ~ext[ch];
			cyc(3);
			apb(1'b0, 8'(8'h0c + 4 * ch), 32'h0);
			check(rdat, m);
			if (ch == 0) run <= 1'b1;
			else evt_req <= 1'b1;
			cyc(1);
			run     <= 1'b0;
			evt_req <= 1'b0;
			cyc(3);
			apb(1'b0, 8'(8'h0c + 4 * ch), 32'h0);
			check(rdat, {16'h0, ctr[ch]});
		end
		// buffer flag blocks both uses of reg c, then releases it
		apb(1'b1, 8'h1c, 32'h1);
		apb(1'b1, 8'h00, 32'h5);
		cyc(2);
		check(poe[0], 1'b0);
		apb(1'b1, 8'h00, 32'ha);
		m = {16'h0, 16'($urandom)};
		apb(1'b1, 8'h0c, m);
		ext[0] <= ~ext[0];
		cyc(3);
		ext[0] <= ~ext[0];
		cyc(3);
		apb(1'b0, 8'h0c, 32'h0);
		check(rdat, m);
		apb(1'b1, 8'h1c, 32'h0);
		ext[0] <= ~ext[0];
		cyc(3);
		apb(1'b0, 8'h0c, 32'h0);
		check(rdat, {16'h0, ctr[0]});
		end_of_test();
	end
endmodule // tb_top

`default_nettype wire

/* testbench/tioc_far_model.sv */
`default_nettype none

// ---------------------------------------------------------------
// far side: counters, cascade sources and external pin drivers
// ---------------------------------------------------------------
module tioc_far_model (
	// clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	// requests from the bench
	input  wire logic        run,
	input  wire logic        evt_req,
	input  wire logic [2:0]  ext,
	// design pin drive
	input  wire logic [2:0]  out,
	input  wire logic [2:0]  oe,
	// towards the design
	output logic      [15:0] cnt,
	output logic             cnt_evt,
	output logic             reg_a_evt,
	output logic      [2:0]  pin
);
	timeunit 1ns;
	timeprecision 1ps;

	// counter steps only while run is held, flagging each step
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt     <= 16'h0000;
			cnt_evt <= 1'b0;
		end else begin
			cnt     <= cnt + {15'h0000, run};
			cnt_evt <= run;
		end
	end

	// one-cycle compare or capture pulse of the neighbour's reg a
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_a_evt <= 1'b0;
		end else begin
			reg_a_evt <= evt_req;
		end
	end

	// wire level: the design's drive wins while it is enabled
	assign pin = (oe & out) | (~oe & ext);
endmodule // tioc_far_model

`default_nettype wire
